// ---- gerr_global_error_flags.sv ----
// Global error flag register with clear-on-read and summary outputs
// How it works
// - Watchdog timeout of either watchdog sets bit 7
// - Watchdog flag only when a watchdog enabled
// - Watchdog flag feeds communication error summary
// - Ground loss sets bit 6
// - Ground loss feeds supply error summary
// - Thermal shutdown sets bit 5, feeds overload
// - Flags latched; read clears only absent causes
// - Internal undervoltage flag set at power-up
// - Warning and low drive fault unless masked; reset ignores the mask and drives it
`timescale 1ns/1ps
`default_nettype none
module gerr_global_error_flags
    import gerr_pkg::*;
(
    input  wire logic       sys_clk,                 // 40 MHz clock
    input  wire logic       sys_rst,                 // Sync reset, high
    input  wire logic       reg_rd,                  // Register read strobe
    input  wire logic [3:0] reg_addr,                // Register address
    input  wire logic [1:0] serial_watchdog_timeout_select, // 0 = off
    input  wire logic       sync_watchdog_enable,    // Sync watchdog on
    input  wire logic       serial_wd_timeout,       // Serial watchdog expired
    input  wire logic       sync_wd_timeout,         // Sync watchdog expired
    input  wire logic       ground_loss_det,         // Ground lost
    input  wire logic       thermal_shutdown_det,    // In thermal shutdown
    input  wire logic       field_uvlo_det,          // Field supply under lockout
    input  wire logic       supply_warn_det,         // Field supply below warning
    input  wire logic       supply_low_det,          // Field supply below good
    input  wire logic       logic_uv_det,            // Logic supply under lockout
    input  wire logic       internal_uv_det,         // Internal supply lost
    input  wire logic       supply_good_fault_mask,  // Masks supply fault pin
    output logic [7:0]      reg_rdata,               // Read data
    output logic            reg_rvalid,              // Read data valid pulse
    output logic            communication_error_summary, // To interrupt reg
    output logic            supply_error_summary,    // To interrupt reg
    output logic            overload_fault_summary,  // To interrupt reg
    output logic            fault_pin_active         // Fault pin request
);
    import gerr_pkg::*;

    // ========================================
    // Read timing
    // Strobe at this address sampled at edge c0
    // From c1: rdata holds flags from before c0, rvalid high one cycle
    // Clear lands at c0, so a read right behind sees it
    // Reset clears the ground flag; host still masks it on its first read

    // ========================================
    // Helper functions

    // Timeouts only count while their watchdog is switched on
    function automatic logic wd_cause(
        input logic [1:0] sel,
        input logic       sync_en,
        input logic       serial_to,
        input logic       sync_to
    );
        logic serial_hit;
        logic sync_hit;

        serial_hit = (sel != WDT_OFF) && serial_to;
        sync_hit   = sync_en && sync_to;
        return serial_hit || sync_hit;
    endfunction

    // Per bit: a live cause sets, else a read clears, else hold
    function automatic logic [7:0] next_flags(
        input logic [7:0] held,
        input logic [7:0] cause,
        input logic       clear
    );
        logic [7:0] nxt;
        nxt = held;
        for (int i = 0; i < GERR_WIDTH; i++) begin
            if (cause[i]) begin
                nxt[i] = 1'b1;
            end else if (clear) begin
                nxt[i] = 1'b0;
            end
        end
        return nxt;
    endfunction

    // Watchdog is the only communication fault here
    function automatic logic comm_or(
        input logic [7:0] flags
    );
        return flags[BIT_WATCHDOG];
    endfunction

    // No disable bit modelled: every field supply fault counts
    function automatic logic supply_or(
        input logic [7:0] flags
    );
        logic any_err;

        any_err = 1'b0;
        any_err = any_err | flags[BIT_GROUND_LOSS];
        any_err = any_err | flags[BIT_FIELD_UVLO];
        any_err = any_err | flags[BIT_SUPPLY_WARN];
        any_err = any_err | flags[BIT_SUPPLY_LOW];
        return any_err;
    endfunction

    // Thermal shutdown is the only overload cause here
    function automatic logic overload_or(
        input logic [7:0] flags
    );
        return flags[BIT_THERMAL];
    endfunction

    // Only warning and low drive the pin; other faults do not
    function automatic logic fault_drive(
        input logic [7:0] flags,
        input logic       mask
    );
        logic low_supply;

        low_supply = flags[BIT_SUPPLY_WARN] || flags[BIT_SUPPLY_LOW];
        return !mask && low_supply;
    endfunction

    // ========================================
    // State

    // Registered state and its next value
    gerr_state_s st_ff;
    gerr_state_s nxt_st;

    // Decoded inputs
    logic [7:0]  cond;
    logic        wd_live;
    logic        rd_hit;

    // ========================================
    // Live fault conditions
    // Causes are levels; one cycle is enough to set a flag

    assign wd_live = wd_cause(serial_watchdog_timeout_select,
                              sync_watchdog_enable,
                              serial_wd_timeout,
                              sync_wd_timeout);

    always_comb begin
        cond                  = '0;

        // Device faults
        cond[BIT_WATCHDOG]    = wd_live;
        cond[BIT_GROUND_LOSS] = ground_loss_det;
        cond[BIT_THERMAL]     = thermal_shutdown_det;

        // Supply faults
        cond[BIT_FIELD_UVLO]  = field_uvlo_det;
        cond[BIT_SUPPLY_WARN] = supply_warn_det;
        cond[BIT_SUPPLY_LOW]  = supply_low_det;
        cond[BIT_LOGIC_UV]    = logic_uv_det;
        cond[BIT_INTERNAL_UV] = internal_uv_det;
    end

    // ========================================
    // Read decode

    // Other addresses are ignored and raise no valid pulse
    // Back-to-back reads are fine: rvalid stays high one cycle per read
    assign rd_hit = reg_rd && (reg_addr == GERR_ADDR);

    // ========================================
    // Next state

    always_comb begin
        nxt_st = st_ff;

        // Host sees the value from before the clear
        nxt_st.rvalid = rd_hit;
        if (rd_hit) begin
            nxt_st.rdata = st_ff.flags;
        end else begin
            nxt_st.rdata = st_ff.rdata;
        end

        // Flags latch until read with the cause gone
        nxt_st.flags = next_flags(st_ff.flags, cond, rd_hit);

        // Summaries follow the new flags at the same edge
        nxt_st.comm_err     = comm_or(nxt_st.flags);
        nxt_st.supply_err   = supply_or(nxt_st.flags);
        nxt_st.overload_err = overload_or(nxt_st.flags);
        nxt_st.fault_pin    = fault_drive(nxt_st.flags, supply_good_fault_mask);
    end

    // ========================================
    // Registers

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_ff.flags        <= GERR_RESET;
            st_ff.rdata        <= 8'h00;
            st_ff.rvalid       <= 1'b0;
            st_ff.comm_err     <= comm_or(GERR_RESET);
            st_ff.supply_err   <= supply_or(GERR_RESET);
            st_ff.overload_err <= overload_or(GERR_RESET);
            // Mask bit lives elsewhere, so the pin shows supply faults
            st_ff.fault_pin    <= fault_drive(GERR_RESET, 1'b0);
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ========================================
    // Outputs
    // Every output is a flop, no logic behind it

    assign reg_rdata                   = st_ff.rdata;
    assign reg_rvalid                  = st_ff.rvalid;
    assign communication_error_summary = st_ff.comm_err;
    assign supply_error_summary        = st_ff.supply_err;
    assign overload_fault_summary      = st_ff.overload_err;
    assign fault_pin_active            = st_ff.fault_pin;
endmodule
`default_nettype wire

// ---- gerr_pkg.sv ----
// Constants for the global error flag register
package gerr_pkg;
    // ========================================
    // Register map
    localparam logic [3:0] GERR_ADDR          = 4'h7;
    localparam int         GERR_WIDTH         = 8;
    // ========================================
    // Field positions
    localparam int         BIT_WATCHDOG       = 7;
    localparam int         BIT_GROUND_LOSS    = 6;
    localparam int         BIT_THERMAL        = 5;
    localparam int         BIT_FIELD_UVLO     = 4;
    localparam int         BIT_SUPPLY_WARN    = 3;
    localparam int         BIT_SUPPLY_LOW     = 2;
    localparam int         BIT_LOGIC_UV       = 1;
    localparam int         BIT_INTERNAL_UV    = 0;
    // ========================================
    // Reset value: supply flags set, fault flags clear
    localparam logic [7:0] GERR_RESET         = 8'h1f;
    localparam logic [1:0] WDT_OFF            = 2'h0;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] rdata;
        logic       rvalid;
        logic       comm_err;
        logic       supply_err;
        logic       overload_err;
        logic       fault_pin;
    } gerr_state_s;
endpackage

// ---- gerr_host.sv ----
// Host model that issues register reads
`timescale 1ns/1ps
`default_nettype none
module gerr_host(input wire logic sys_clk, reg_rvalid, input wire logic [7:0] reg_rdata,
    output logic reg_rd, output logic [3:0] reg_addr);
    initial {reg_rd, reg_addr} = 5'h00;
    // Address inverted on release so a stale value is never read as valid
    task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic v);
        @(negedge sys_clk) {reg_rd, reg_addr} = {1'b1, a};
        @(negedge sys_clk) {reg_rd, reg_addr, d, v} = {1'b0, ~a, reg_rdata, reg_rvalid};
    endtask
endmodule
`default_nettype wire

// ---- gerr_chk.sv ----
// Checker for the global error flag register
`timescale 1ns/1ps
`default_nettype none
module gerr_chk import gerr_pkg::*; (input wire logic sys_clk, sys_rst, reg_rd, reg_rvalid, serial_wd_timeout,
    sync_watchdog_enable, ground_loss_det, thermal_shutdown_det, supply_warn_det, supply_good_fault_mask,
    communication_error_summary, supply_error_summary, overload_fault_summary, fault_pin_active,
    input wire logic [3:0] reg_addr, input wire logic [1:0] serial_watchdog_timeout_select);
    wire rd = reg_rd && reg_addr == GERR_ADDR;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_read_answer: assert property (rd |=> reg_rvalid) else $error("no answer");
    a_wd_set: assert property (serial_wd_timeout && serial_watchdog_timeout_select != WDT_OFF
        |=> communication_error_summary) else $error("wd lost");
    a_wd_off: assert property (!communication_error_summary && !sync_watchdog_enable &&
        serial_watchdog_timeout_select == WDT_OFF |=> !communication_error_summary) else $error("wd off");
    a_gnd_set: assert property (ground_loss_det |=> supply_error_summary) else $error("gnd");
    a_hot_set: assert property (thermal_shutdown_det |=> overload_fault_summary) else $error("hot");
    a_hot_held: assert property (overload_fault_summary && !rd |=> overload_fault_summary) else $error("held");
    a_pin_on: assert property (supply_warn_det && !supply_good_fault_mask |=> fault_pin_active) else $error("pin");
    a_pin_mask: assert property (supply_good_fault_mask |=> !fault_pin_active) else $error("mask");
    a_other_quiet: assert property (reg_rd && reg_addr != GERR_ADDR |=> !reg_rvalid) else $error("stray");
    a_hot_clear: assert property (rd && !thermal_shutdown_det |=> !overload_fault_summary) else $error("clr");
endmodule
bind gerr_global_error_flags gerr_chk gerr_chk_i (.*);
`default_nettype wire

// ---- global_error_status_register_tb.sv ----
// Testbench for the global error flag register
`timescale 1ns/1ps
`default_nettype none
module global_error_status_register_tb;
    import gerr_pkg::*;
    logic sys_clk = 0, sys_rst = 1, wen = 0, wts = 0, wty = 0, msk = 0, v;
    logic [1:0] wsel = 0;
    logic [6:0] det = 0;
    logic [7:0] d;
    wire rd, rv, comm, sup, ovl, pin;
    wire [3:0] addr;
    wire [7:0] rdat, sums = {4'h0, comm, sup, ovl, pin};
    int fails = 0, compares = 0, cyc = 0;
    initial forever #12.5 sys_clk = ~sys_clk;
    gerr_global_error_flags gerr_global_error_flags_i(.sys_clk, .sys_rst, .reg_rd(rd), .reg_addr(addr),
        .serial_watchdog_timeout_select(wsel), .sync_watchdog_enable(wen), .serial_wd_timeout(wts),
        .sync_wd_timeout(wty), .ground_loss_det(det[6]), .thermal_shutdown_det(det[5]), .field_uvlo_det(det[4]),
        .supply_warn_det(det[3]), .supply_low_det(det[2]), .logic_uv_det(det[1]), .internal_uv_det(det[0]),
        .supply_good_fault_mask(msk), .reg_rdata(rdat), .reg_rvalid(rv), .communication_error_summary(comm),
        .supply_error_summary(sup), .overload_fault_summary(ovl), .fault_pin_active(pin));
    gerr_host gerr_host_i(.sys_clk, .reg_rvalid(rv), .reg_rdata(rdat), .reg_rd(rd), .reg_addr(addr));
    task automatic chk(input string n, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin fails++; $display("FAIL %s exp %h got %h", n, e, g); end
    endtask
    task automatic rdx(input logic [7:0] e, m = 8'hff);
        gerr_host_i.rd(GERR_ADDR, d, v);
        chk("rvalid", 8'h01, {7'h0, v});
        chk("rdata", e, d & m);
    endtask
    task automatic t_reset;
        chk("summary", 8'h05, sums);
        rdx(8'h1f, 8'hbf);
        gerr_host_i.rd(4'h3, d, v);
        chk("rvalid", 8'h00, {7'h0, v});
        rdx(8'h00);
    endtask
    task automatic t_wd;
        for (int i = 0; i < 2; i++) begin
            {wts, wty} = 2'h3;
            rdx(8'h00);
            if (i) wen = 1; else wsel = 2'h1;
            @(negedge sys_clk) {wts, wty, wen, wsel} = 5'h00;
            chk("summary", 8'h08, sums);
            rdx(8'h80);
            rdx(8'h00);
        end
    endtask
    task automatic t_hold;
        @(negedge sys_clk) det = 7'h73;
        @(negedge sys_clk) chk("summary", 8'h06, sums);
        rdx(8'h73);
        rdx(8'h73);
        det = 7'h00;
        rdx(8'h73);
        rdx(8'h00);
    endtask
    task automatic t_pin;
        @(negedge sys_clk) {det, msk} = {7'h0c, 1'b1};
        @(negedge sys_clk) chk("summary", 8'h04, sums);
        @(negedge sys_clk) msk = 0;
        @(negedge sys_clk) chk("summary", 8'h05, sums);
    endtask
    task automatic t_rerun;
        @(negedge sys_clk) sys_rst = 1;
        repeat (2) @(negedge sys_clk);
        sys_rst = 0;
        chk("summary", 8'h05, sums);
        rdx(8'h1f, 8'hbf);
        rdx(8'h0c);
    endtask
    // Whole run is about 50 cycles
    always @(posedge sys_clk) if (++cyc == 2000) begin fails++; wrap_up; end
    task automatic wrap_up;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge sys_clk);
        sys_rst = 0;
        t_reset;
        t_wd;
        t_hold;
        t_pin;
        t_rerun;
        wrap_up;
    end
endmodule
`default_nettype wire
